/* hdl/vst_consts.svh */
`ifndef VST_CONSTS_SVH
`define VST_CONSTS_SVH

// Timing
`define VST_CLK_NS 100
`define VST_HS_NS 4700
`define VST_HS_CYC (`VST_HS_NS / `VST_CLK_NS)
`define VST_SYNC_LEAD 32
`define VST_FIELD_LAG_BIN 148
`define VST_FIELD_LAG_BOUT 138
`define VST_MASTER_S50 4
`define VST_BLK_OFS_SET 4
`define VST_BLK_OFS_CLR 2
`define VST_PIPE 26
`define VST_TIP_BEG 13
`define VST_BURST_BEG 66
`define VST_BURST_LEN 24

// Frame geometry
`define VST_LINES_525 11'h20D
`define VST_LINES_625 11'h271
`define VST_VS_HL_3 11'h006
`define VST_VS_HL_25 11'h005

// Setup exclusion line ranges
`define VST_XN_A0 10'h001
`define VST_XN_A1 10'h015
`define VST_XN_B0 10'h107
`define VST_XN_B1 10'h11C
`define VST_XM_A0 10'h20B
`define VST_XM_A1 10'h012
`define VST_XM_B0 10'h104
`define VST_XM_B1 10'h119
`define VST_XP_A0 10'h26F
`define VST_XP_A1 10'h016
`define VST_XP_B0 10'h137
`define VST_XP_B1 10'h14F

// Output levels
`define VST_LVL_SYNC 10'h010
`define VST_LVL_BLANK 10'h0F0
`define VST_LVL_SETUP 10'h02A
`endif

/* hdl/vst_dly.sv */
`timescale 1ns/1ns
module vst_dly #(
  parameter int W = 1,
  parameter int D = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [D-1:0][W-1:0] sh;
  } vst_dly_st_t;

  vst_dly_st_t st_q;
  vst_dly_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.sh = {st_q.sh[D-2:0], i_d};
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_q = st_q.sh[D-1];
endmodule : vst_dly

/* hdl/vst_pkg.sv */
package vst_pkg;

  typedef enum logic [2:0] {
    VST_NTSC_M = 3'b000,
    VST_PAL_M = 3'b001,
    VST_PAL_N = 3'b010,
    VST_PAL_BGHI = 3'b011,
    VST_PAL_NC = 3'b100
  } vst_std_t;

  typedef struct packed {
    logic sync_out;
    logic blank_out;
    logic half_rate;
    logic blank_tsel;
    vst_std_t std;
    logic setup_en;
    logic [11:0] h_total;
    logic [11:0] act_start;
    logic [11:0] act_stop;
    logic [9:0] vb_start;
    logic [9:0] vb_stop;
    logic [11:0] win_start;
    logic [11:0] win_stop;
    logic win_trail;
    logic win_field;
    logic [10:0] v_preset;
  } vst_cfg_t;

  typedef struct packed {
    logic phase;
    logic [11:0] hcnt;
    logic [10:0] vhalf;
    logic hs_s;
    logic hs_p;
    logic vs_s;
    logic vs_p;
    logic bl_s;
    logic [7:0] fdly;
    logic frun;
    logic [11:0] wcnt;
    logic wrun;
    logic whit;
    logic wval;
    logic field;
    logic hs_n;
    logic vs_n;
    logic bl_n;
    logic hs_oe;
    logic vs_oe;
    logic bl_oe;
    logic [9:0] video;
    logic burst;
  } vst_state_t;

  function automatic logic vst_in_rng(input logic [11:0] v,
                                      input logic [11:0] a,
                                      input logic [11:0] b);
    if (a <= b) begin
      return (v >= a) && (v <= b);
    end
    return (v >= a) || (v <= b);
  endfunction : vst_in_rng

endpackage : vst_pkg

/* hdl/vst_timing.sv */
`timescale 1ns/1ns
`include "vst_consts.svh"
module vst_timing (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Configuration
  input wire vst_pkg::vst_cfg_t i_cfg,
  // Line sync pin
  input wire logic i_hsync_n,
  output logic o_hsync_n,
  output logic o_hsync_oe,
  // Frame sync pin
  input wire logic i_vsync_n,
  output logic o_vsync_n,
  output logic o_vsync_oe,
  // Blanking pin
  input wire logic i_blank_n,
  output logic o_blank_n,
  output logic o_blank_oe,
  // Field parity
  output logic o_field,
  // Pixel path
  input wire logic [15:0] i_pixel,
  input wire logic i_vbi_line,
  output logic [9:0] o_video,
  output logic o_burst
);
  import vst_pkg::*;

  localparam vst_state_t ST_RST = '{
    hs_s: 1'b1, hs_p: 1'b1, vs_s: 1'b1, vs_p: 1'b1, bl_s: 1'b1,
    hs_n: 1'b1, vs_n: 1'b1, bl_n: 1'b1, default: '0
  };

  vst_state_t s_q;
  vst_state_t s_d;

  logic [1:0] sync_raw;
  logic [1:0] sync_dly;
  logic [9:0] pipe_in;
  logic [9:0] pipe_out;

  // ---------------------------------------------------------------
  // Output sync delay, lets field lead the syncs in master mode
  // ---------------------------------------------------------------
  vst_dly #(
    .W(2),
    .D(`VST_SYNC_LEAD)
  ) u_sync_dly (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d(sync_raw),
    .o_q(sync_dly)
  );

  // ---------------------------------------------------------------
  // Pixel pipeline, one more stage is the video register
  // ---------------------------------------------------------------
  vst_dly #(
    .W(10),
    .D(`VST_PIPE - 1)
  ) u_pix_dly (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d(pipe_in),
    .o_q(pipe_out)
  );

  always_comb begin
    logic slave;
    logic upd;
    logic smp;
    logic is625;
    logic [10:0] lines;
    logic [10:0] vshl;
    logic [11:0] tot;
    logic [11:0] pos;
    logic [11:0] bpos;
    logic [11:0] ofs;
    logic [11:0] hpix;
    logic [10:0] fl;
    logic [9:0] fln;
    logic hs_edge;
    logic vs_lead;
    logic vs_trail;
    logic wedge;
    logic [7:0] ftgt;
    logic raw_vs;
    logic hact;
    logic vact;
    logic blank_gen;
    logic blanked;
    logic setup_ok;
    logic tip;
    logic hit;
    slave = 1'b0;
    upd = 1'b0;
    smp = 1'b0;
    is625 = 1'b0;
    lines = '0;
    vshl = '0;
    tot = '0;
    pos = '0;
    bpos = '0;
    ofs = '0;
    hpix = '0;
    fl = '0;
    fln = '0;
    hs_edge = 1'b0;
    vs_lead = 1'b0;
    vs_trail = 1'b0;
    wedge = 1'b0;
    ftgt = '0;
    raw_vs = 1'b0;
    hact = 1'b0;
    vact = 1'b0;
    blank_gen = 1'b0;
    blanked = 1'b0;
    setup_ok = 1'b0;
    tip = 1'b0;
    hit = 1'b0;
    s_d = s_q;

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    slave = ~i_cfg.sync_out;
    upd = ~i_cfg.half_rate | s_q.phase;
    smp = ~i_cfg.half_rate | ~s_q.phase;
    s_d.phase = ~s_q.phase;
    is625 = (i_cfg.std == VST_PAL_N) || (i_cfg.std == VST_PAL_BGHI) ||
            (i_cfg.std == VST_PAL_NC);
    lines = is625 ? `VST_LINES_625 : `VST_LINES_525;
    case (i_cfg.std)
      VST_NTSC_M, VST_PAL_M, VST_PAL_N: vshl = `VST_VS_HL_3;
      default: vshl = `VST_VS_HL_25;
    endcase
    tot = i_cfg.h_total;

    // ---------------------------------------------------------------
    // Input sampling, gated by half-rate phase when enabled
    // ---------------------------------------------------------------
    if (smp) begin
      s_d.hs_s = i_hsync_n;
      s_d.hs_p = s_q.hs_s;
      s_d.vs_s = i_vsync_n;
      s_d.vs_p = s_q.vs_s;
      s_d.bl_s = i_blank_n;
    end
    hs_edge = upd & s_q.hs_p & ~s_q.hs_s;
    vs_lead = upd & s_q.vs_p & ~s_q.vs_s;
    vs_trail = upd & ~s_q.vs_p & s_q.vs_s;

    // ---------------------------------------------------------------
    // Line and half-line counters
    // ---------------------------------------------------------------
    if (s_q.hcnt >= tot - 12'h001) begin
      s_d.hcnt = '0;
      s_d.vhalf = (s_q.vhalf >= 11'((lines << 1) - 11'h001)) ? '0 :
                  s_q.vhalf + 11'h001;
    end else begin
      s_d.hcnt = s_q.hcnt + 12'h001;
    end
    if (slave && hs_edge) begin
      s_d.hcnt = '0;
      s_d.vhalf = s_q.vhalf[0] ? s_d.vhalf : s_q.vhalf;
    end
    if (slave && vs_lead) begin
      s_d.vhalf = i_cfg.v_preset;
    end
    pos = s_q.vhalf[0] ? s_q.hcnt + tot : s_q.hcnt;
    fln = 10'(s_q.vhalf >> 1) + 10'h001;
    fl = (s_q.vhalf >= lines) ? ((s_q.vhalf - lines) >> 1) :
         (s_q.vhalf >> 1);

    // ---------------------------------------------------------------
    // Field window in slave mode
    // ---------------------------------------------------------------
    wedge = i_cfg.win_trail ? vs_trail : vs_lead;
    if (slave && wedge) begin
      s_d.wrun = 1'b1;
      s_d.wcnt = '0;
    end else if (s_q.wrun) begin
      s_d.wcnt = s_q.wcnt + 12'h001;
      if (s_q.wcnt >= i_cfg.win_stop) begin
        s_d.wrun = 1'b0;
      end
    end
    // Offset from the chosen edge is wcnt + 1; a coincident edge is 0
    hit = hs_edge && slave &&
          ((wedge && (i_cfg.win_start == 12'h000)) ||
           (s_q.wrun && (s_q.wcnt + 12'h001 >= i_cfg.win_start) &&
            (s_q.wcnt + 12'h001 <= i_cfg.win_stop)));

    // ---------------------------------------------------------------
    // Field parity
    // ---------------------------------------------------------------
    ftgt = i_cfg.blank_out ? 8'(`VST_FIELD_LAG_BOUT) :
           8'(`VST_FIELD_LAG_BIN);
    if (slave) begin
      if (vs_lead) begin
        s_d.frun = 1'b1;
        s_d.fdly = '0;
      end else if (s_q.frun) begin
        s_d.fdly = s_q.fdly + 8'h01;
        if (s_q.fdly >= ftgt - 8'h01 && upd) begin
          s_d.frun = 1'b0;
          s_d.field = s_q.whit ? s_q.wval : ~s_q.field;
          s_d.whit = 1'b0;
        end
      end
    end else if (upd) begin
      s_d.field = (s_q.vhalf >= lines);
    end
    // A hit in the update cycle wins over the clear
    if (hit) begin
      s_d.whit = 1'b1;
      s_d.wval = i_cfg.win_field;
    end

    // ---------------------------------------------------------------
    // Master syncs, delayed so field leads them
    // ---------------------------------------------------------------
    raw_vs = (s_q.vhalf < vshl) ||
             ((s_q.vhalf >= lines) && (s_q.vhalf < lines + vshl));
    sync_raw = {pos < 12'(`VST_HS_CYC), raw_vs};
    if (upd) begin
      s_d.hs_n = ~(i_cfg.sync_out & sync_dly[1]);
      s_d.vs_n = ~(i_cfg.sync_out & sync_dly[0]);
    end
    s_d.hs_oe = i_cfg.sync_out;
    s_d.vs_oe = i_cfg.sync_out;

    // ---------------------------------------------------------------
    // Blanking generation
    // ---------------------------------------------------------------
    ofs = i_cfg.blank_tsel ? 12'(`VST_BLK_OFS_SET) :
          12'(`VST_BLK_OFS_CLR);
    bpos = (pos >= ofs) ? pos - ofs : 12'(pos + (tot << 1) - ofs);
    hpix = bpos >> 1;
    hact = vst_in_rng(hpix, i_cfg.act_start,
                      i_cfg.act_stop - 12'h001);
    vact = (fl >= 11'(i_cfg.vb_stop)) &&
           (fl < 11'(i_cfg.vb_start));
    blank_gen = ~(hact & vact);
    if (upd) begin
      s_d.bl_n = ~(i_cfg.blank_out & blank_gen);
    end
    s_d.bl_oe = i_cfg.blank_out;
    blanked = i_cfg.blank_out ? blank_gen : ~s_q.bl_s;

    // ---------------------------------------------------------------
    // Setup exclusion
    // ---------------------------------------------------------------
    case (i_cfg.std)
      VST_NTSC_M: begin
        setup_ok = ~vst_in_rng(12'(fln), 12'(`VST_XN_A0), 12'(`VST_XN_A1)) &
                   ~vst_in_rng(12'(fln), 12'(`VST_XN_B0), 12'(`VST_XN_B1));
      end
      VST_PAL_M: begin
        setup_ok = ~vst_in_rng(12'(fln), 12'(`VST_XM_A0), 12'(`VST_XM_A1)) &
                   ~vst_in_rng(12'(fln), 12'(`VST_XM_B0), 12'(`VST_XM_B1));
      end
      default: begin
        setup_ok = ~vst_in_rng(12'(fln), 12'(`VST_XP_A0), 12'(`VST_XP_A1)) &
                   ~vst_in_rng(12'(fln), 12'(`VST_XP_B0), 12'(`VST_XP_B1));
      end
    endcase
    setup_ok = setup_ok & i_cfg.setup_en;

    // ---------------------------------------------------------------
    // Black burst and pixel insertion
    // ---------------------------------------------------------------
    pipe_in = {blanked | i_vbi_line, setup_ok, i_pixel[15:8]};
    tip = (pos >= 12'(`VST_TIP_BEG)) &&
          (pos < 12'(`VST_TIP_BEG + `VST_HS_CYC));
    s_d.burst = (pos >= 12'(`VST_BURST_BEG)) && ~raw_vs &&
                (pos < 12'(`VST_BURST_BEG + `VST_BURST_LEN));
    if (tip) begin
      s_d.video = `VST_LVL_SYNC;
    end else if (pipe_out[9]) begin
      s_d.video = `VST_LVL_BLANK;
    end else begin
      s_d.video = `VST_LVL_BLANK + 10'(pipe_out[7:0]) +
                  (pipe_out[8] ? `VST_LVL_SETUP : 10'h000);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_hsync_n = s_q.hs_n;
  assign o_hsync_oe = s_q.hs_oe;
  assign o_vsync_n = s_q.vs_n;
  assign o_vsync_oe = s_q.vs_oe;
  assign o_blank_n = s_q.bl_n;
  assign o_blank_oe = s_q.bl_oe;
  assign o_field = s_q.field;
  assign o_video = s_q.video;
  assign o_burst = s_q.burst;
endmodule : vst_timing

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import vst_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  vst_cfg_t i_cfg = '0;
  logic [15:0] i_pixel = 16'h0000;
  logic s_run = 1'b0;
  logic s_hs_n, s_vs_n, s_bl_n, hs_w, vs_w, bl_w;
  logic o_hsync_n, o_hsync_oe, o_vsync_n, o_vsync_oe;
  logic o_blank_n, o_blank_oe, o_field;
  logic [9:0] o_video;
  logic o_burst;
  logic vbi = 1'b0;
  logic [11:0] tw = 12'h000;
  logic [11:0] bw = 12'h000;
  logic fld_p = 1'b0;
  logic [11:0] wid = 12'h000;
  logic [11:0] e;
  logic [11:0] exp_q[$];
  logic [11:0] f_q[$];
  int failures = 0;
  int num_checks = 0;
  int seed = 95;
  assign hs_w = (o_hsync_oe === 1'b1) ? o_hsync_n : s_hs_n;
  assign vs_w = (o_vsync_oe === 1'b1) ? o_vsync_n : s_vs_n;
  assign bl_w = (o_blank_oe === 1'b1) ? o_blank_n : s_bl_n;
  always #50 i_clk = !i_clk;
  vst_src src_u (.i_clk, .i_run(s_run), .o_hsync_n(s_hs_n),
    .o_vsync_n(s_vs_n), .o_blank_n(s_bl_n));
  vst_timing dut_u (.i_clk, .i_reset, .i_cfg, .i_hsync_n(hs_w),
    .o_hsync_n, .o_hsync_oe, .i_vsync_n(vs_w), .o_vsync_n,
    .o_vsync_oe, .i_blank_n(bl_w), .o_blank_n, .o_blank_oe,
    .o_field, .i_pixel, .i_vbi_line(vbi), .o_video, .o_burst);
  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic start(input logic so, input logic bo);
    @(negedge i_clk);
    i_reset = 1'b1;
    s_run <= 1'b0;
    i_cfg.sync_out = so;
    i_cfg.blank_out = bo;
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    s_run <= !so;
  endtask : start
  // Counts frame sync leading edges on the pin
  task automatic wait_vs(input int n);
    logic p;
    p = vs_w;
    repeat (30000) begin
      @(posedge i_clk);
      if (p === 1'b1 && vs_w === 1'b0) n = n - 1;
      p = vs_w;
      if (n == 0) return;
    end
    failures++;
    report_and_stop();
  endtask : wait_vs
  // ----------------------------
  // Stimulus and monitors
  // ----------------------------
  always @(negedge i_clk) begin
    i_pixel <= 16'($random(seed));
    vbi <= 1'($random(seed));
  end
  // Sync tip and burst widths are fixed by the standard (master only)
  always @(posedge i_clk) begin
    if (i_reset === 1'b1 || i_cfg.sync_out !== 1'b1) begin
      tw = 12'h000;
      bw = 12'h000;
    end else begin
      if (o_video === 10'h010) begin
        tw = tw + 12'h001;
      end else if (tw != 12'h000) begin
        check(tw, 12'h02F);
        tw = 12'h000;
      end
      if (o_burst === 1'b1) begin
        bw = bw + 12'h001;
      end else if (bw != 12'h000) begin
        check(bw, 12'h018);
        bw = 12'h000;
      end
    end
  end
  always @(posedge i_clk) begin
    if (o_blank_oe === 1'b1 && o_blank_n === 1'b1) begin
      wid = wid + 12'h001;
    end else begin
      if (wid != 12'h000) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'h000;
        check(wid, e);
      end
      wid = 12'h000;
    end
    if (i_reset === 1'b0 && i_cfg.sync_out === 1'b0 && o_field !== fld_p)
    begin
      e = (f_q.size() > 0) ? f_q.pop_front() : 12'hFFF;
      check({11'h000, o_field}, e);
    end
    fld_p = o_field;
  end
  initial begin
    i_cfg.std = VST_NTSC_M;
    i_cfg.blank_tsel = 1'b1;
    i_cfg.h_total = 12'h030;
    i_cfg.act_start = 12'h00A;
    i_cfg.act_stop = 12'h02A;
    i_cfg.vb_stop = 10'h014;
    i_cfg.vb_start = 10'h0FA;
    i_cfg.win_stop = 12'h004;
    i_cfg.win_field = 1'b1;
    // Master: one odd field of unblanked lines, both blank timings
    for (int t = 0; t < 2; t++) begin
      @(negedge i_clk);
      i_cfg.blank_tsel = !t[0];
      i_cfg.std = t[0] ? VST_PAL_M : VST_NTSC_M;
      repeat (230) exp_q.push_back(12'h040);
      start(1'b1, 1'b1);
      wait_vs(2);
      check(12'(exp_q.size()), 12'h000);
    end
    // Slave: window hit on odd fields holds the field at one
    for (int b = 0; b < 2; b++) begin
      f_q = '{12'h001, 12'h000, 12'h001};
      start(1'b0, b[0]);
      wait_vs(4);
      repeat (160) @(posedge i_clk);
      check(12'(f_q.size()), 12'h000);
    end
    report_and_stop();
  end
endmodule : tb_top

/* verif/vst_src.sv */
`timescale 1ns/1ns
module vst_src #(
  parameter int LINE = 96,
  parameter int LINES = 6
) (
  // Clock and run enable
  input wire logic i_clk,
  input wire logic i_run,
  // Timing toward the encoder
  output logic o_hsync_n = 1'b1,
  output logic o_vsync_n = 1'b1,
  output logic o_blank_n = 1'b1
);
  int p = 0;
  int hl = 2 * LINES;
  // Starts on an even field; odd field edges coincide
  always @(negedge i_clk) begin
    if (!i_run) begin
      p = 0;
      hl = 2 * LINES;
    end else if (p == LINE / 2 - 1) begin
      p = 0;
      hl = (hl == 4 * LINES + 1) ? 0 : hl + 1;
    end else begin
      p = p + 1;
    end
    o_hsync_n <= !(i_run && hl % 2 == 0 && p < 47);
    o_vsync_n <= !(i_run && hl % (2 * LINES + 1) < 6);
    o_blank_n <= i_run && hl % 2 == 1;
  end
endmodule : vst_src

/* verif/vst_timing_assertions.sv */
`timescale 1ns/1ns
module vst_timing_checker (
  // Clock, reset and setup
  input wire logic i_clk,
  input wire logic i_reset,
  input wire vst_pkg::vst_cfg_t i_cfg,
  // Pins
  input wire logic i_vsync_n,
  input wire logic o_hsync_n,
  input wire logic o_hsync_oe,
  input wire logic o_vsync_n,
  input wire logic o_vsync_oe,
  input wire logic o_blank_oe,
  input wire logic o_field
);
  import vst_pkg::*;
  // ----------------------------
  // Pulse and edge counters
  // ----------------------------
  logic [11:0] hl_q;
  logic [11:0] vl_q;
  logic [11:0] ph_q;
  logic [11:0] sv_q;
  logic [11:0] vsw;
  assign vsw = 12'(i_cfg.h_total *
               ((i_cfg.std <= VST_PAL_N) ? 12'h006 : 12'h005));
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hl_q <= 12'h000;
      vl_q <= 12'h000;
      ph_q <= 12'h000;
      sv_q <= 12'h000;
    end else begin
      hl_q <= o_hsync_n ? 12'h000 : hl_q + 12'h001;
      vl_q <= o_vsync_n ? 12'h000 : vl_q + 12'h001;
      ph_q <= $fell(o_hsync_n) ? 12'h001 : ph_q + 12'h001;
      sv_q <= $fell(i_vsync_n) ? 12'h000 : sv_q + 12'h001;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------
  // Checks
  // ----------------------------
  a_hsync_width: assert property (
    $rose(o_hsync_n) && o_hsync_oe |-> hl_q == 12'h02F)
    else $error("line sync width wrong");
  a_vsync_width: assert property (
    $rose(o_vsync_n) && o_vsync_oe |-> vl_q == vsw)
    else $error("frame sync width wrong");
  a_odd_edges: assert property (
    $fell(o_vsync_n) && o_vsync_oe && !o_field |-> $fell(o_hsync_n))
    else $error("odd field syncs apart");
  a_even_midline: assert property (
    $fell(o_vsync_n) && o_vsync_oe && o_field |-> ph_q == i_cfg.h_total)
    else $error("even field sync not mid-line");
  a_field_lead: assert property (
    $changed(o_field) && o_vsync_oe |-> ##32 $fell(o_vsync_n))
    else $error("field does not lead frame sync");
  a_lag_blank_in: assert property (
    $changed(o_field) && !i_cfg.sync_out && !i_cfg.blank_out &&
    !i_cfg.half_rate |-> sv_q inside {[12'h091:12'h099]})
    else $error("field lag wrong, blank in");
  a_lag_blank_out: assert property (
    $changed(o_field) && !i_cfg.sync_out && i_cfg.blank_out &&
    !i_cfg.half_rate |-> sv_q inside {[12'h087:12'h08F]})
    else $error("field lag wrong, blank out");
  a_oe_follow: assert property (
    1'b1 |-> ##1 {o_hsync_oe, o_vsync_oe, o_blank_oe} ==
    {i_cfg.sync_out, i_cfg.sync_out, i_cfg.blank_out})
    else $error("pin direction wrong");
endmodule : vst_timing_checker

bind vst_timing vst_timing_checker chk_u (
  .i_clk, .i_reset, .i_cfg, .i_vsync_n, .o_hsync_n, .o_hsync_oe,
  .o_vsync_n, .o_vsync_oe, .o_blank_oe, .o_field);
